// file: logic/suc_link_if.sv
// Signals between the control register logic and the serial shift engine.
// Both ends run on clk_sys.
interface suc_link_if;
  logic nineBit;
  logic rxEnable;
  logic txGo;
  logic [7:0] txByte;
  logic txNinth;
  logic txBusy;
  logic tiEvent;
  logic txLine;
  logic rxDone;
  logic [7:0] rxByte;
  logic rxNinth;

  modport ctl (
    output nineBit, rxEnable, txGo, txByte, txNinth,
    input txBusy, tiEvent, txLine, rxDone, rxByte, rxNinth
  );
  modport eng (
    input nineBit, rxEnable, txGo, txByte, txNinth,
    output txBusy, tiEvent, txLine, rxDone, rxByte, rxNinth
  );
endinterface

// file: logic/suc_pkg.sv
// Constants shared by the serial port control block and its shift engine.
// Assumes one 40 MHz system clock and a single control register on the SFR port.
package suc_pkg;
  // Register location and layout.
  localparam logic [7:0] SUC_CTL_ADDR = 8'h98;
  localparam logic [4:0] SUC_CTL_BITBASE = 5'h13;
  localparam logic [7:0] SUC_CTL_RESET = 8'h40;
  localparam int BIT_MODE = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_MCE = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TB8 = 3;
  localparam int BIT_RB8 = 2;
  localparam int BIT_TI = 1;
  localparam int BIT_RI = 0;
  // Line timing.
  localparam int CLK_HZ = 40000000;
  localparam int BAUD_BPS = 115200;
  localparam int OVERSAMPLE = 16;
  localparam int TICK_DIV = CLK_HZ / (BAUD_BPS * OVERSAMPLE);
  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);
  localparam logic [3:0] PHASE_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] PHASE_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] RX_BITS8 = 4'h8;
  localparam logic [3:0] RX_BITS9 = 4'h9;
  localparam logic [2:0] TX_LASTBIT = 3'h7;

  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} suc_rx_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} suc_tx_state_t;
endpackage

// file: logic/suc_serial_control.sv
// Serial port control register, flags and interrupt request, with its shift engine.
// Assumes the processor reaches the register on a byte/bit SFR port on clk_sys,
// and that the data byte to send arrives with txStart from a buffer outside.
module suc_serial_control
  import suc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // SFR byte access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // SFR bit access
  input wire logic [7:0] sfrBitAddr,
  input wire logic sfrBitWrite,
  input wire logic sfrBitVal,
  // Transmit data
  input wire logic txStart,
  input wire logic [7:0] txData,
  output logic txBusy,
  // Receive data
  output logic [7:0] rxData,
  output logic rxStrobe,
  // Interrupt
  input wire logic intEnable,
  output logic irq,
  // Serial pins
  input wire logic rxdPin,
  output logic txdPin
);
  suc_link_if lnk ();

  suc_shifter u_shifter (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rxdPin(rxdPin),
    .lnk(lnk)
  );

  logic mode_r, mode_nxt, mce_r, mce_nxt, ren_r, ren_nxt, tb8_r, tb8_nxt;
  logic rb8_r, rb8_nxt, ti_r, ti_nxt, ri_r, ri_nxt;
  logic [7:0] rdData_r, rdData_nxt, rxData_r, rxData_nxt;
  logic rxStb_r, rxStb_nxt, irq_r, irq_nxt, busy_r, busy_nxt;
  logic [7:0] ctlNow, ctlWr;

  // Applies a byte write or a single-bit write to the control value.
  function automatic logic [7:0] apply_write(input logic [7:0] cur, input logic byteWr,
                                             input logic [7:0] data, input logic bitWr,
                                             input logic [7:0] bitAddr, input logic bitVal);
    logic [7:0] res;
    res = cur;
    if (byteWr) begin
      res = data;
    end
    if (bitWr && bitAddr[7:3] == SUC_CTL_BITBASE) begin
      res[bitAddr[2:0]] = bitVal;
    end
    return res;
  endfunction

  always_comb begin
    ctlNow = {mode_r, 1'b1, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
    ctlWr = apply_write(ctlNow, sfrWrite && sfrAddr == SUC_CTL_ADDR, sfrWrData,
                        sfrBitWrite, sfrBitAddr, sfrBitVal);
    // Bit 6 is held constant, so a careless write cannot disturb it.
    mode_nxt = ctlWr[BIT_MODE];
    mce_nxt = ctlWr[BIT_MCE];
    ren_nxt = ctlWr[BIT_REN];
    tb8_nxt = ctlWr[BIT_TB8];
    rb8_nxt = ctlWr[BIT_RB8];
    ti_nxt = ctlWr[BIT_TI];
    ri_nxt = ctlWr[BIT_RI];
    rxData_nxt = rxData_r;
    rxStb_nxt = 1'b0;
    // Hardware events are applied after software writes, so a set wins over a clear.
    if (lnk.tiEvent) begin
      ti_nxt = 1'b1;
    end
    if (lnk.rxDone) begin
      rb8_nxt = lnk.rxNinth;
      if (!mce_r || lnk.rxNinth) begin
        ri_nxt = 1'b1;
        rxData_nxt = lnk.rxByte;
        rxStb_nxt = 1'b1;
      end
    end
    irq_nxt = intEnable && (ti_nxt || ri_nxt);
    busy_nxt = lnk.txBusy || lnk.txGo;
    rdData_nxt = 8'h00;
    if (sfrRead && sfrAddr == SUC_CTL_ADDR) begin
      rdData_nxt = ctlNow;
    end
  end

  // A start request while a frame is in flight is dropped.
  assign lnk.txGo = txStart && !lnk.txBusy;
  assign lnk.txByte = txData;
  assign lnk.txNinth = tb8_r;
  assign lnk.nineBit = mode_r;
  assign lnk.rxEnable = ren_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_r <= SUC_CTL_RESET[BIT_MODE];
      mce_r <= SUC_CTL_RESET[BIT_MCE];
      ren_r <= SUC_CTL_RESET[BIT_REN];
      tb8_r <= SUC_CTL_RESET[BIT_TB8];
      rb8_r <= SUC_CTL_RESET[BIT_RB8];
      ti_r <= SUC_CTL_RESET[BIT_TI];
      ri_r <= SUC_CTL_RESET[BIT_RI];
      rdData_r <= 8'h00;
      rxData_r <= 8'h00;
      rxStb_r <= 1'b0;
      irq_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      mce_r <= mce_nxt;
      ren_r <= ren_nxt;
      tb8_r <= tb8_nxt;
      rb8_r <= rb8_nxt;
      ti_r <= ti_nxt;
      ri_r <= ri_nxt;
      rdData_r <= rdData_nxt;
      rxData_r <= rxData_nxt;
      rxStb_r <= rxStb_nxt;
      irq_r <= irq_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign sfrRdData = rdData_r;
  assign rxData = rxData_r;
  assign rxStrobe = rxStb_r;
  assign irq = irq_r;
  assign txBusy = busy_r;
  assign txdPin = lnk.txLine;
endmodule

// file: logic/suc_shifter.sv
// Serial shift engine: start bit, data LSB first, optional ninth bit, stop bit.
// Assumes rxdPin is asynchronous; everything else is on clk_sys.
module suc_shifter
  import suc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial input pin
  input wire logic rxdPin,
  // Control side
  suc_link_if.eng lnk
);
  logic [7:0] divCnt_r, divCnt_nxt;
  logic tick;
  logic rxS1_r, rxS2_r;
  suc_rx_state_t rxSt_r, rxSt_nxt;
  logic [3:0] rxPh_r, rxPh_nxt, rxCnt_r, rxCnt_nxt;
  logic [8:0] rxSh_r, rxSh_nxt;
  logic rxDone_r, rxDone_nxt, rxNinth_r, rxNinth_nxt;
  logic [7:0] rxByte_r, rxByte_nxt;
  suc_tx_state_t txSt_r, txSt_nxt;
  logic [3:0] txPh_r, txPh_nxt;
  logic [2:0] txCnt_r, txCnt_nxt;
  logic [7:0] txSh_r, txSh_nxt;
  logic txN_r, txN_nxt, txLine_r, txLine_nxt, tiEv_r, tiEv_nxt;

  // Oversampling tick divider.
  always_comb begin
    divCnt_nxt = (divCnt_r == TICK_LAST) ? 8'h00 : divCnt_r + 8'h01;
    tick = (divCnt_r == TICK_LAST);
  end

  // Receiver.
  always_comb begin
    rxSt_nxt = rxSt_r;
    rxPh_nxt = rxPh_r;
    rxCnt_nxt = rxCnt_r;
    rxSh_nxt = rxSh_r;
    rxDone_nxt = 1'b0;
    rxByte_nxt = rxByte_r;
    rxNinth_nxt = rxNinth_r;
    if (tick) begin
      rxPh_nxt = rxPh_r + 4'h1;
      case (rxSt_r)
        RX_IDLE: begin
          rxPh_nxt = 4'h0;
          if (lnk.rxEnable && !rxS2_r) begin
            rxSt_nxt = RX_START;
          end
        end
        RX_START: begin
          if (rxPh_r == PHASE_MID) begin
            rxPh_nxt = 4'h0;
            rxCnt_nxt = 4'h0;
            rxSt_nxt = rxS2_r ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (rxPh_r == PHASE_LAST) begin
            rxSh_nxt[rxCnt_r] = rxS2_r;
            rxCnt_nxt = rxCnt_r + 4'h1;
            if (rxCnt_nxt == (lnk.nineBit ? RX_BITS9 : RX_BITS8)) begin
              rxSt_nxt = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxPh_r == PHASE_LAST) begin
            rxSt_nxt = RX_IDLE;
            rxDone_nxt = 1'b1;
            rxByte_nxt = rxSh_r[7:0];
            rxNinth_nxt = lnk.nineBit ? rxSh_r[8] : rxS2_r;
          end
        end
        default: rxSt_nxt = RX_IDLE;
      endcase
    end
  end

  // Transmitter.
  always_comb begin
    txSt_nxt = txSt_r;
    txPh_nxt = txPh_r;
    txCnt_nxt = txCnt_r;
    txSh_nxt = txSh_r;
    txN_nxt = txN_r;
    txLine_nxt = txLine_r;
    tiEv_nxt = 1'b0;
    case (txSt_r)
      TX_IDLE: begin
        txLine_nxt = 1'b1;
        if (lnk.txGo) begin
          txSt_nxt = TX_START;
          txSh_nxt = lnk.txByte;
          txN_nxt = lnk.txNinth;
          txPh_nxt = 4'h0;
          txLine_nxt = 1'b0;
        end
      end
      default: begin
        if (tick) begin
          txPh_nxt = txPh_r + 4'h1;
          if (txPh_r == PHASE_LAST) begin
            case (txSt_r)
              TX_START: begin
                txSt_nxt = TX_DATA;
                txCnt_nxt = 3'h0;
                txLine_nxt = txSh_r[0];
              end
              TX_DATA: begin
                txSh_nxt = {1'b0, txSh_r[7:1]};
                txCnt_nxt = txCnt_r + 3'h1;
                if (txCnt_r != TX_LASTBIT) begin
                  txLine_nxt = txSh_r[1];
                end else if (lnk.nineBit) begin
                  txSt_nxt = TX_NINTH;
                  txLine_nxt = txN_r;
                end else begin
                  txSt_nxt = TX_STOP;
                  txLine_nxt = 1'b1;
                  tiEv_nxt = 1'b1;
                end
              end
              TX_NINTH: begin
                txSt_nxt = TX_STOP;
                txLine_nxt = 1'b1;
                tiEv_nxt = 1'b1;
              end
              default: begin
                txSt_nxt = TX_IDLE;
                txLine_nxt = 1'b1;
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      divCnt_r <= 8'h00;
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
      rxSt_r <= RX_IDLE;
      rxPh_r <= 4'h0;
      rxCnt_r <= 4'h0;
      rxSh_r <= 9'h000;
      rxDone_r <= 1'b0;
      rxByte_r <= 8'h00;
      rxNinth_r <= 1'b0;
      txSt_r <= TX_IDLE;
      txPh_r <= 4'h0;
      txCnt_r <= 3'h0;
      txSh_r <= 8'h00;
      txN_r <= 1'b0;
      txLine_r <= 1'b1;
      tiEv_r <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      rxS1_r <= rxdPin;
      rxS2_r <= rxS1_r;
      rxSt_r <= rxSt_nxt;
      rxPh_r <= rxPh_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxSh_r <= rxSh_nxt;
      rxDone_r <= rxDone_nxt;
      rxByte_r <= rxByte_nxt;
      rxNinth_r <= rxNinth_nxt;
      txSt_r <= txSt_nxt;
      txPh_r <= txPh_nxt;
      txCnt_r <= txCnt_nxt;
      txSh_r <= txSh_nxt;
      txN_r <= txN_nxt;
      txLine_r <= txLine_nxt;
      tiEv_r <= tiEv_nxt;
    end
  end

  assign lnk.txBusy = (txSt_r != TX_IDLE);
  assign lnk.tiEvent = tiEv_r;
  assign lnk.txLine = txLine_r;
  assign lnk.rxDone = rxDone_r;
  assign lnk.rxByte = rxByte_r;
  assign lnk.rxNinth = rxNinth_r;
endmodule

// file: verif/suc_remote_uart.sv
// Remote UART on the far end of the serial line.
// Assumes a bit time of 336 system clocks.
module suc_remote_uart (
  // Clock
  input wire logic clk_sys,
  // Line
  input wire logic txdPin,
  output logic rxdPin
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT_CLKS = 336;
  logic [10:0] gotBits = '0;
  int gotCount = 0;
  initial rxdPin = 1'h1;
  // The eleventh bit is idle high, so one word serves both frame lengths.
  task automatic sendFrame(input logic [8:0] bits);
    logic [10:0] fw;
    fw = {1'h1, bits, 1'h0};
    for (int i = 0; i < 11; i++) begin
      rxdPin <= fw[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask
  always begin
    @(negedge txdPin);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      gotBits[i] = txdPin;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    gotCount++;
  end
endmodule

// file: verif/suc_serial_control_sva.sv
// Port checker for the serial port control block.
// Assumes one clk_sys domain with a synchronous active-low reset.
module suc_serial_control_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRead,
  input wire logic [7:0] sfrRdData,
  // Line and data
  input wire logic txStart,
  input wire logic txBusy,
  input wire logic txdPin,
  input wire logic [7:0] rxData,
  input wire logic rxStrobe,
  // Interrupt
  input wire logic intEnable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_rd_other; sfrRead && sfrAddr != 8'h98 |=> sfrRdData == 8'h00; endproperty
  a_rd_other: assert property (p_rd_other) else $error("stray read");
  property p_rd_rsvd; sfrRead && sfrAddr == 8'h98 |=> sfrRdData[6]; endproperty
  a_rd_rsvd: assert property (p_rd_rsvd) else $error("bit 6 low");
  property p_tx_go; txStart && !txBusy |=> !txdPin && txBusy; endproperty
  a_tx_go: assert property (p_tx_go) else $error("no start bit");
  property p_start_low; $rose(txBusy) |-> !txdPin [*8]; endproperty
  a_start_low: assert property (p_start_low) else $error("short start");
  property p_idle_high; !txBusy |-> txdPin; endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle low");
  property p_no_irq; !intEnable |=> !irq; endproperty
  a_no_irq: assert property (p_no_irq) else $error("masked irq");
  property p_rx_irq; rxStrobe && intEnable |-> ##[0:1] irq; endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("no irq");
  property p_rx_hold; $changed(rxData) |-> rxStrobe; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("data moved");
  c_rx: cover property (rxStrobe && intEnable);
  c_tx: cover property ($fell(txBusy));
  c_ref: cover property (txStart && txBusy);
endmodule
bind suc_serial_control suc_serial_control_chk suc_serial_control_chk_inst (.clk_sys, .resetn,
  .sfrAddr, .sfrRead, .sfrRdData, .txStart, .txBusy, .txdPin, .rxData, .rxStrobe, .intEnable,
  .irq);

// file: verif/suc_serial_control_tb.sv
// Bench for the serial port control block with a remote UART on its line.
// Assumes a 336-clock bit time; the run takes about 45k cycles.
module suc_serial_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic mode;
    logic multidrop_check_enable;
    logic ren;
    logic [8:0] bits;
    logic expStrobe;
    logic expRb8;
  } suc_row_t;
  logic clk_sys, resetn, sfrWrite, sfrRead, sfrBitWrite, sfrBitVal, txStart, txBusy;
  logic rxStrobe, intEnable, irq, rxdPin, txdPin, gotStrobe;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, sfrBitAddr, txData, rxData, gotData, v;
  logic [10:0] gb;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int w, n;
  suc_row_t r;
  // Bit 8 is the stop bit in 8-bit rows and the ninth bit in 9-bit rows.
  suc_row_t rows [8] = '{
    {3'h1, 9'h15a, 2'h3}, {3'h1, 9'h03c, 2'h2}, {3'h3, 9'h0a5, 2'h0}, {3'h3, 9'h1c3, 2'h3},
    {3'h7, 9'h066, 2'h0}, {3'h7, 9'h199, 2'h3}, {3'h5, 9'h024, 2'h2}, {3'h0, 9'h1ff, 2'h0}};
  suc_serial_control suc_serial_control_inst (.clk_sys, .resetn, .sfrAddr, .sfrWrite, .sfrRead,
    .sfrWrData, .sfrRdData, .sfrBitAddr, .sfrBitWrite, .sfrBitVal, .txStart, .txData, .txBusy,
    .rxData, .rxStrobe, .intEnable, .irq, .rxdPin, .txdPin);
  suc_remote_uart suc_remote_uart_inst (.clk_sys, .txdPin, .rxdPin);
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic doReset();
    resetn <= 1'h0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
  endtask
  task automatic wrReg(input logic [7:0] d);
    sfrAddr <= 8'h98;
    sfrWrData <= d | 8'h40;
    sfrWrite <= 1'h1;
    @(posedge clk_sys);
    sfrWrite <= 1'h0;
  endtask
  task automatic wrBit(input logic [7:0] a, input logic b);
    sfrBitAddr <= a;
    sfrBitVal <= b;
    sfrBitWrite <= 1'h1;
    @(posedge clk_sys);
    sfrBitWrite <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    sfrAddr <= a;
    sfrRead <= 1'h1;
    @(posedge clk_sys);
    sfrRead <= 1'h0;
    @(posedge clk_sys);
    d = sfrRdData;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (rxStrobe === 1'h1) begin
      gotStrobe = 1'h1;
      gotData = rxData;
    end
    if (cycles == 70000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {resetn, sfrWrite, sfrRead, sfrBitWrite, sfrBitVal, txStart, intEnable} = '0;
    {sfrAddr, sfrWrData, sfrBitAddr, txData} = '0;
    gotStrobe = 1'h0;
    doReset();
    intEnable <= 1'h1;
    foreach (rows[i]) begin
      r = rows[i];
      wrReg({r.mode, 1'h0, r.multidrop_check_enable, r.ren, 4'h0});
      gotStrobe = 1'h0;
      suc_remote_uart_inst.sendFrame(r.bits);
      repeat (400) @(posedge clk_sys);
      rdReg(8'h98, v);
      chk(8'(gotStrobe), 8'(r.expStrobe));
      chk(8'(v[0]), 8'(r.expStrobe));
      chk(8'(v[2]), 8'(r.expRb8));
      if (r.expStrobe) chk(gotData, r.bits[7:0]);
    end
    doReset();
    rdReg(8'h98, v);
    chk(v, 8'h40);
    wrBit(8'h9e, 1'h0);
    wrBit(8'h9f, 1'h1);
    wrBit(8'h90, 1'h1);
    rdReg(8'h98, v);
    chk(v, 8'hc0);
    rdReg(8'h99, v);
    chk(v, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wrReg({k > 0, 3'h0, k == 1, 3'h0});
      n = suc_remote_uart_inst.gotCount;
      txData <= 8'hc3 ^ 8'(k);
      txStart <= 1'h1;
      @(posedge clk_sys);
      txStart <= 1'h0;
      repeat (40) @(posedge clk_sys);
      txData <= 8'h00;
      txStart <= 1'h1;
      @(posedge clk_sys);
      txStart <= 1'h0;
      for (w = 0; irq !== 1'h1 && w < 5000; w++) @(posedge clk_sys);
      chk(8'({txBusy, txdPin}), 8'h03);
      for (w = 0; suc_remote_uart_inst.gotCount == n && w < 5000; w++) @(posedge clk_sys);
      gb = suc_remote_uart_inst.gotBits;
      chk(gb[8:1], 8'hc3 ^ 8'(k));
      chk(8'({gb[10:9], gb[0]}), (k == 2) ? 8'h04 : 8'h06);
      rdReg(8'h98, v);
      chk(8'({irq, v[1]}), 8'h03);
    end
    // The transmit flag is still set here, so only the enable decides the request.
    intEnable <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk(8'(irq), 8'h00);
    intEnable <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk(8'(irq), 8'h01);
    wrap_up();
  end
endmodule
